// ---- hw/gpiobcd_pkg.sv ----
package gpiobcd_pkg;

    // bus geometry
    localparam int ADDR_W = 5;
    localparam int DATA_W = 32;
    localparam int REG_W = 8;

    // register indices, byte address is four times the index
    localparam logic [2:0] IDX_PORT_B_LATCH = 3'h1;
    localparam logic [2:0] IDX_PORT_C_LATCH = 3'h2;
    localparam logic [2:0] IDX_PORT_D_LATCH = 3'h3;
    localparam logic [2:0] IDX_PORT_B_DIRECTION = 3'h5;
    localparam logic [2:0] IDX_PORT_C_DIRECTION = 3'h6;
    localparam logic [2:0] IDX_PORT_D_DIRECTION = 3'h7;

    // port widths
    localparam int PORT_B_W = 8;
    localparam int PORT_C_W = 5;
    localparam int PORT_D_W = 7;

    // field positions
    localparam int SYSCLK_OUT_BIT = 2;
    localparam int SYSCLK_EN_BIT = 7;
    localparam int TIMER_CLK_BIT = 6;

    // analog channel layout
    localparam int ANALOG_CH_COUNT = 15;
    localparam int ANALOG_D_BASE = 8;

    // prescale code that picks the external pin clock
    localparam logic [2:0] TIMER_EXT_SEL = 3'h7;

    // reset values
    localparam logic [7:0] DIR_B_RESET = 8'h00;
    localparam logic [4:0] DIR_C_RESET = 5'h00;
    localparam logic [6:0] DIR_D_RESET = 7'h00;
    localparam logic SYSCLK_EN_RESET = 1'b0;

    // bus responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // register selected by an address
    typedef enum logic [2:0] {
        SEL_NONE,
        SEL_B_LATCH,
        SEL_C_LATCH,
        SEL_D_LATCH,
        SEL_B_DIR,
        SEL_C_DIR,
        SEL_D_DIR
    } gpiobcd_sel_t;

    // a captured write request
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [REG_W-1:0] data;
        logic strb;
    } gpiobcd_wreq_t;

endpackage : gpiobcd_pkg

// ---- hw/gpiobcd_top.sv ----
// Function
// - data bits are software latches steered by direction bits, untouched by reset
// - direction one enables the pin driver, zero leaves the pin floating
// - reset clears all direction bits so every pin starts as input
// - data reads give latch for outputs and live pin level for inputs
// - latch writes always land, input pins stay undriven
// - analog-selected port B bit reads zero as input, latch as output
// - port B direction never drives analog pins but still picks latch or zero
// - clock output enable, direction C bit 7, drives system clock on C pin 2
// - clock output overrides C bit 2 direction; reset clears the enable
// - port C has five bits, port D has seven bits
// - port D pins are analog channels eight to fourteen, same read rule
// - port D direction never drives timer pin but picks latch or zero
// - external timer clock select feeds D pin 6 to timer, direction ignored
module gpiobcd_top (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // axi4-lite write address
    input wire logic [gpiobcd_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // axi4-lite write data
    input wire logic [gpiobcd_pkg::DATA_W-1:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // axi4-lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read address
    input wire logic [gpiobcd_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // axi4-lite read data
    output logic [gpiobcd_pkg::DATA_W-1:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // port b pins
    input wire logic [gpiobcd_pkg::PORT_B_W-1:0] pin_b_in,
    output logic [gpiobcd_pkg::PORT_B_W-1:0] pin_b_out,
    output logic [gpiobcd_pkg::PORT_B_W-1:0] pin_b_oe_n,
    // port c pins
    input wire logic [gpiobcd_pkg::PORT_C_W-1:0] pin_c_in,
    output logic [gpiobcd_pkg::PORT_C_W-1:0] pin_c_out,
    output logic [gpiobcd_pkg::PORT_C_W-1:0] pin_c_oe_n,
    // port d pins
    input wire logic [gpiobcd_pkg::PORT_D_W-1:0] pin_d_in,
    output logic [gpiobcd_pkg::PORT_D_W-1:0] pin_d_out,
    output logic [gpiobcd_pkg::PORT_D_W-1:0] pin_d_oe_n,
    // converter and timer links
    input wire logic [4:0] analog_channel_select,
    input wire logic [2:0] timer_prescale_select,
    output logic timer_ext_clock_in
);

    localparam int PIN_W = gpiobcd_pkg::PORT_B_W + gpiobcd_pkg::PORT_C_W
        + gpiobcd_pkg::PORT_D_W;

    // map a byte address onto a register
    function automatic gpiobcd_pkg::gpiobcd_sel_t decode_addr(
        input logic [gpiobcd_pkg::ADDR_W-1:0] addr
    );
        gpiobcd_pkg::gpiobcd_sel_t sel;
        sel = gpiobcd_pkg::SEL_NONE;
        if (addr[1:0] == 2'h0)
        begin
            case (addr[gpiobcd_pkg::ADDR_W-1:2])
                gpiobcd_pkg::IDX_PORT_B_LATCH: sel = gpiobcd_pkg::SEL_B_LATCH;
                gpiobcd_pkg::IDX_PORT_C_LATCH: sel = gpiobcd_pkg::SEL_C_LATCH;
                gpiobcd_pkg::IDX_PORT_D_LATCH: sel = gpiobcd_pkg::SEL_D_LATCH;
                gpiobcd_pkg::IDX_PORT_B_DIRECTION: sel = gpiobcd_pkg::SEL_B_DIR;
                gpiobcd_pkg::IDX_PORT_C_DIRECTION: sel = gpiobcd_pkg::SEL_C_DIR;
                gpiobcd_pkg::IDX_PORT_D_DIRECTION: sel = gpiobcd_pkg::SEL_D_DIR;
                default: sel = gpiobcd_pkg::SEL_NONE;
            endcase
        end
        return sel;
    endfunction : decode_addr

    // one-hot analog channel
    function automatic logic [gpiobcd_pkg::ANALOG_CH_COUNT-1:0] channel_onehot(
        input logic [4:0] sel
    );
        logic [gpiobcd_pkg::ANALOG_CH_COUNT-1:0] hot;
        hot = '0;
        for (int i = 0; i < gpiobcd_pkg::ANALOG_CH_COUNT; i++)
        begin
            hot[i] = (sel == 5'(i));
        end
        return hot;
    endfunction : channel_onehot

    // software visible state
    logic [gpiobcd_pkg::PORT_B_W-1:0] port_b_latch;
    logic [gpiobcd_pkg::PORT_C_W-1:0] port_c_latch;
    logic [gpiobcd_pkg::PORT_D_W-1:0] port_d_latch;
    logic [gpiobcd_pkg::PORT_B_W-1:0] port_b_direction;
    logic [gpiobcd_pkg::PORT_C_W-1:0] port_c_direction;
    logic [gpiobcd_pkg::PORT_D_W-1:0] port_d_direction;
    logic sysclk_out_enable;

    // write channel capture
    logic aw_held;
    logic w_held;
    gpiobcd_pkg::gpiobcd_wreq_t wreq;
    logic do_write;
    logic wr_en;
    gpiobcd_pkg::gpiobcd_sel_t wr_sel;

    // pin sampling
    logic [PIN_W-1:0] pin_s1;
    logic [PIN_W-1:0] pin_s2;
    logic [PIN_W-1:0] pin_s3;
    logic [PIN_W-1:0] pin_level;
    logic [gpiobcd_pkg::PORT_B_W-1:0] lvl_b;
    logic [gpiobcd_pkg::PORT_C_W-1:0] lvl_c;
    logic [gpiobcd_pkg::PORT_D_W-1:0] lvl_d;

    // alternate function decode
    logic [gpiobcd_pkg::ANALOG_CH_COUNT-1:0] analog_hot;
    logic [gpiobcd_pkg::PORT_B_W-1:0] analog_b;
    logic [gpiobcd_pkg::PORT_D_W-1:0] special_d;
    logic timer_pin_sel;

    // read values and pin controls
    logic [gpiobcd_pkg::PORT_B_W-1:0] rd_b;
    logic [gpiobcd_pkg::PORT_C_W-1:0] rd_c;
    logic [gpiobcd_pkg::PORT_D_W-1:0] rd_d;
    logic [gpiobcd_pkg::REG_W-1:0] rd_value;
    logic rd_mapped;
    logic [gpiobcd_pkg::PORT_B_W-1:0] next_drive_b;
    logic [gpiobcd_pkg::PORT_C_W-1:0] next_drive_c;
    logic [gpiobcd_pkg::PORT_D_W-1:0] next_drive_d;
    logic [gpiobcd_pkg::PORT_C_W-1:0] next_pin_c_out;
    logic sysclk_phase;

    // handshake readiness: one write and one read in flight
    assign s_axi_awready = !aw_held;
    assign s_axi_wready = !w_held;
    assign s_axi_arready = !s_axi_rvalid;
    assign do_write = aw_held && w_held && !s_axi_bvalid;
    assign wr_sel = decode_addr(wreq.addr);
    assign wr_en = do_write && wreq.strb;

    // write address capture
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            aw_held <= 1'b0;
            wreq.addr <= '0;
        end
        else if (s_axi_awvalid && !aw_held)
        begin
            aw_held <= 1'b1;
            wreq.addr <= s_axi_awaddr;
        end
        else if (do_write)
        begin
            aw_held <= 1'b0;
        end
    end

    // write data capture, low byte lane only
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            w_held <= 1'b0;
            wreq.data <= '0;
            wreq.strb <= 1'b0;
        end
        else if (s_axi_wvalid && !w_held)
        begin
            w_held <= 1'b1;
            wreq.data <= s_axi_wdata[gpiobcd_pkg::REG_W-1:0];
            wreq.strb <= s_axi_wstrb[0];
        end
        else if (do_write)
        begin
            w_held <= 1'b0;
        end
    end

    // write response once both halves are in
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= gpiobcd_pkg::RESP_OKAY;
        end
        else if (do_write)
        begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (wr_sel == gpiobcd_pkg::SEL_NONE) ?
                gpiobcd_pkg::RESP_SLVERR : gpiobcd_pkg::RESP_OKAY;
        end
        else if (s_axi_bready)
        begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // data latches keep their contents through reset
    always_ff @(posedge clk_sys)
    begin
        if (wr_en && wr_sel == gpiobcd_pkg::SEL_B_LATCH)
        begin
            port_b_latch <= wreq.data[gpiobcd_pkg::PORT_B_W-1:0];
        end
        if (wr_en && wr_sel == gpiobcd_pkg::SEL_C_LATCH)
        begin
            port_c_latch <= wreq.data[gpiobcd_pkg::PORT_C_W-1:0];
        end
        if (wr_en && wr_sel == gpiobcd_pkg::SEL_D_LATCH)
        begin
            port_d_latch <= wreq.data[gpiobcd_pkg::PORT_D_W-1:0];
        end
    end

    // direction registers and clock output enable
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            port_b_direction <= gpiobcd_pkg::DIR_B_RESET;
            port_c_direction <= gpiobcd_pkg::DIR_C_RESET;
            port_d_direction <= gpiobcd_pkg::DIR_D_RESET;
            sysclk_out_enable <= gpiobcd_pkg::SYSCLK_EN_RESET;
        end
        else if (wr_en)
        begin
            case (wr_sel)
                gpiobcd_pkg::SEL_B_DIR:
                    port_b_direction <= wreq.data[gpiobcd_pkg::PORT_B_W-1:0];
                gpiobcd_pkg::SEL_C_DIR:
                begin
                    port_c_direction <= wreq.data[gpiobcd_pkg::PORT_C_W-1:0];
                    sysclk_out_enable <= wreq.data[gpiobcd_pkg::SYSCLK_EN_BIT];
                end
                gpiobcd_pkg::SEL_D_DIR:
                    port_d_direction <= wreq.data[gpiobcd_pkg::PORT_D_W-1:0];
                default:
                    port_b_direction <= port_b_direction;
            endcase
        end
    end

    // three-stage pin sampler with agreement filter
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            pin_s1 <= '0;
            pin_s2 <= '0;
            pin_s3 <= '0;
            pin_level <= '0;
        end
        else
        begin
            pin_s1 <= {pin_d_in, pin_c_in, pin_b_in};
            pin_s2 <= pin_s1;
            pin_s3 <= pin_s2;
            pin_level <= (pin_s2 & ~(pin_s2 ^ pin_s3)) | (pin_level & (pin_s2 ^ pin_s3));
        end
    end

    // per-port levels
    assign lvl_b = pin_level[gpiobcd_pkg::PORT_B_W-1:0];
    assign lvl_c = pin_level[gpiobcd_pkg::PORT_B_W +: gpiobcd_pkg::PORT_C_W];
    assign lvl_d = pin_level[PIN_W-1 -: gpiobcd_pkg::PORT_D_W];

    // converter and timer pin use
    assign analog_hot = channel_onehot(analog_channel_select);
    assign analog_b = analog_hot[gpiobcd_pkg::PORT_B_W-1:0];
    assign timer_pin_sel = (timer_prescale_select == gpiobcd_pkg::TIMER_EXT_SEL);

    // port d alternate use mask
    always_comb
    begin
        special_d = analog_hot[gpiobcd_pkg::ANALOG_D_BASE +: gpiobcd_pkg::PORT_D_W];
        special_d[gpiobcd_pkg::TIMER_CLK_BIT] = special_d[gpiobcd_pkg::TIMER_CLK_BIT]
            | timer_pin_sel;
    end

    // port b read value
    assign rd_b = (port_b_direction & port_b_latch)
        | (~port_b_direction & ~analog_b & lvl_b);

    // port c read, clock out override on bit 2
    always_comb
    begin
        rd_c = (port_c_direction & port_c_latch) | (~port_c_direction & lvl_c);
        if (sysclk_out_enable)
        begin
            rd_c[gpiobcd_pkg::SYSCLK_OUT_BIT] = port_c_direction[gpiobcd_pkg::SYSCLK_OUT_BIT] ?
                1'b0 : lvl_c[gpiobcd_pkg::SYSCLK_OUT_BIT];
        end
    end

    // port d read value
    assign rd_d = (port_d_direction & port_d_latch)
        | (~port_d_direction & ~special_d & lvl_d);

    // read mux, unused upper bits read as zero
    always_comb
    begin
        rd_value = '0;
        rd_mapped = 1'b1;
        case (decode_addr(s_axi_araddr))
            gpiobcd_pkg::SEL_B_LATCH: rd_value = rd_b;
            gpiobcd_pkg::SEL_C_LATCH: rd_value = {3'h0, rd_c};
            gpiobcd_pkg::SEL_D_LATCH: rd_value = {1'b0, rd_d};
            gpiobcd_pkg::SEL_B_DIR: rd_value = port_b_direction;
            gpiobcd_pkg::SEL_C_DIR: rd_value = {sysclk_out_enable, 2'h0, port_c_direction};
            gpiobcd_pkg::SEL_D_DIR: rd_value = {1'b0, port_d_direction};
            default: rd_mapped = 1'b0;
        endcase
    end

    // read data channel
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= gpiobcd_pkg::RESP_OKAY;
        end
        else if (s_axi_arvalid && !s_axi_rvalid)
        begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= {24'h000000, rd_value};
            s_axi_rresp <= rd_mapped ? gpiobcd_pkg::RESP_OKAY : gpiobcd_pkg::RESP_SLVERR;
        end
        else if (s_axi_rready)
        begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // drive enables: converter and timer pins stay inputs
    always_comb
    begin
        next_drive_b = port_b_direction & ~analog_b;
        next_drive_c = port_c_direction;
        next_drive_c[gpiobcd_pkg::SYSCLK_OUT_BIT] = sysclk_out_enable
            | port_c_direction[gpiobcd_pkg::SYSCLK_OUT_BIT];
        next_drive_d = port_d_direction & ~special_d;
    end

    // port c output data, clock replaces the latch on bit 2
    always_comb
    begin
        next_pin_c_out = port_c_latch;
        if (sysclk_out_enable)
        begin
            next_pin_c_out[gpiobcd_pkg::SYSCLK_OUT_BIT] = sysclk_phase;
        end
    end

    // bus clock image, toggling every cycle
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            sysclk_phase <= 1'b0;
        end
        else
        begin
            sysclk_phase <= !sysclk_phase;
        end
    end

    // registered pin enables, high means floating
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            pin_b_oe_n <= '1;
            pin_c_oe_n <= '1;
            pin_d_oe_n <= '1;
        end
        else
        begin
            pin_b_oe_n <= ~next_drive_b;
            pin_c_oe_n <= ~next_drive_c;
            pin_d_oe_n <= ~next_drive_d;
        end
    end

    // pin data and timer clock
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            pin_b_out <= '0;
            pin_c_out <= '0;
            pin_d_out <= '0;
            timer_ext_clock_in <= 1'b0;
        end
        else
        begin
            pin_b_out <= port_b_latch;
            pin_c_out <= next_pin_c_out;
            pin_d_out <= port_d_latch;
            timer_ext_clock_in <= timer_pin_sel & lvl_d[gpiobcd_pkg::TIMER_CLK_BIT];
        end
    end

endmodule : gpiobcd_top

// ---- testbench/gpiobcd_props.sv ----
module gpiobcd_chk (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // bus handshakes
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // pins and links
    input wire logic [7:0] pin_b_oe_n,
    input wire logic [4:0] pin_c_oe_n,
    input wire logic [6:0] pin_d_in,
    input wire logic [6:0] pin_d_oe_n,
    input wire logic [4:0] analog_channel_select,
    input wire logic [2:0] timer_prescale_select,
    input wire logic timer_ext_clock_in
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);

    logic tps_ext;
    assign tps_ext = timer_prescale_select == gpiobcd_pkg::TIMER_EXT_SEL;

    // drivers off after reset
    chk_reset_drivers_off: assert property ($fell(rst) |->
        &{pin_b_oe_n, pin_c_oe_n, pin_d_oe_n}) else $error("driver on after reset");
    // analog pins never driven
    chk_analog_b_off: assert property (analog_channel_select < 5'h08
        && $stable(analog_channel_select) |-> pin_b_oe_n[analog_channel_select[2:0]])
        else $error("analog b pin driven");
    chk_analog_d_off: assert property (analog_channel_select inside {[8:14]}
        && $stable(analog_channel_select) |-> pin_d_oe_n[analog_channel_select[2:0]])
        else $error("analog d pin driven");
    // timer clock pin
    chk_timer_pin_off: assert property (tps_ext [*3] |-> pin_d_oe_n[6])
        else $error("timer pin driven");
    chk_timer_follow: assert property ((tps_ext && $stable(pin_d_in[6])) [*8]
        |-> timer_ext_clock_in == pin_d_in[6]) else $error("timer clock wrong");
    chk_timer_idle: assert property (!tps_ext [*3] |-> !timer_ext_clock_in)
        else $error("timer clock while unselected");
    // bus answers
    chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read not answered");
    chk_read_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
        && $stable(s_axi_rdata) && $stable(s_axi_rresp)) else $error("read data dropped");
    chk_read_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
        else $error("upper read bits set");
    chk_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
        && s_axi_wready && !s_axi_bvalid |-> ##[1:3] s_axi_bvalid)
        else $error("write not answered");
    chk_write_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
        && $stable(s_axi_bresp)) else $error("write response dropped");

    // main scenarios
    cov_analog_b: cover property (analog_channel_select < 5'h08 && s_axi_rvalid);
    cov_timer_ext: cover property (tps_ext && timer_ext_clock_in);
    cov_write_err: cover property (s_axi_bvalid && s_axi_bresp == gpiobcd_pkg::RESP_SLVERR);
endmodule : gpiobcd_chk

bind gpiobcd_top gpiobcd_chk u_chk (.clk_sys, .rst, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .pin_b_oe_n, .pin_c_oe_n, .pin_d_in, .pin_d_oe_n,
    .analog_channel_select, .timer_prescale_select, .timer_ext_clock_in);

// ---- testbench/gpiobcd_pins.sv ----
module gpiobcd_pins (
    // design pin drivers
    input wire logic [7:0] pin_b_out,
    input wire logic [7:0] pin_b_oe_n,
    input wire logic [4:0] pin_c_out,
    input wire logic [4:0] pin_c_oe_n,
    input wire logic [6:0] pin_d_out,
    input wire logic [6:0] pin_d_oe_n,
    // far side drive levels
    input wire logic [7:0] ext_b,
    input wire logic [4:0] ext_c,
    input wire logic [6:0] ext_d,
    // resolved pin levels
    output logic [7:0] pin_b_in,
    output logic [4:0] pin_c_in,
    output logic [6:0] pin_d_in
);
    timeunit 1ns;
    timeprecision 1ps;
    // an enabled driver wins, a released pin shows the far side level
    assign pin_b_in = (pin_b_oe_n & ext_b) | (~pin_b_oe_n & pin_b_out);
    assign pin_c_in = (pin_c_oe_n & ext_c) | (~pin_c_oe_n & pin_c_out);
    assign pin_d_in = (pin_d_oe_n & ext_d) | (~pin_d_oe_n & pin_d_out);
endmodule : gpiobcd_pins

// ---- testbench/gpiobcd_tb.sv ----
`define CHK(n, e, g) \
    begin \
        n_tests++; \
        if ((g) !== (e)) \
        begin \
            num_errors++; \
            $display("wrong value %s exp %h got %h", n, e, g); \
        end \
    end

module gpiobcd_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [4:0] A_LB = {gpiobcd_pkg::IDX_PORT_B_LATCH, 2'b00};
    localparam logic [4:0] A_LC = {gpiobcd_pkg::IDX_PORT_C_LATCH, 2'b00};
    localparam logic [4:0] A_LD = {gpiobcd_pkg::IDX_PORT_D_LATCH, 2'b00};
    localparam logic [4:0] A_DB = {gpiobcd_pkg::IDX_PORT_B_DIRECTION, 2'b00};
    localparam logic [4:0] A_DC = {gpiobcd_pkg::IDX_PORT_C_DIRECTION, 2'b00};
    localparam logic [4:0] A_DD = {gpiobcd_pkg::IDX_PORT_D_DIRECTION, 2'b00};
    localparam logic [1:0] OK = gpiobcd_pkg::RESP_OKAY;
    localparam logic [1:0] ERR = gpiobcd_pkg::RESP_SLVERR;
    // design signals
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic [4:0] s_axi_awaddr = 5'h00;
    logic [4:0] s_axi_araddr = 5'h00;
    logic [31:0] s_axi_wdata = 32'h0;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    logic [7:0] pin_b_in, pin_b_out, pin_b_oe_n;
    logic [4:0] pin_c_in, pin_c_out, pin_c_oe_n;
    logic [6:0] pin_d_in, pin_d_out, pin_d_oe_n;
    logic [4:0] analog_channel_select = 5'h1F;
    logic [2:0] timer_prescale_select = 3'h0;
    logic timer_ext_clock_in;
    // far side, mirror, scratch
    logic [7:0] ext_b = 8'h00, ext_c = 8'h00, ext_d = 8'h00;
    logic [7:0] lat_b, lat_c, lat_d, dir_b, dir_c, dir_d, sb, sd, e, m, rv;
    logic [63:0] q;
    logic [31:0] r;
    logic [31:0] seed = 32'd80;
    logic [1:0] rr;
    logic [4:0] adr [6] = '{A_LB, A_LC, A_LD, A_DB, A_DC, A_DD};
    logic ck, b, tx;
    int num_errors = 0;
    int n_tests = 0;

    gpiobcd_top DUT (.clk_sys, .rst, .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot(3'h0),
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .pin_b_in, .pin_b_out, .pin_b_oe_n, .pin_c_in, .pin_c_out,
        .pin_c_oe_n, .pin_d_in, .pin_d_out, .pin_d_oe_n, .analog_channel_select,
        .timer_prescale_select, .timer_ext_clock_in);
    gpiobcd_pins PINS (.pin_b_out, .pin_b_oe_n, .pin_c_out, .pin_c_oe_n, .pin_d_out,
        .pin_d_oe_n, .ext_b, .ext_c(ext_c[4:0]), .ext_d(ext_d[6:0]), .pin_b_in, .pin_c_in,
        .pin_d_in);

    // clock
    always #5 clk_sys = ~clk_sys;

    // xorshift source
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd

    // expected read value
    function automatic logic [7:0] rd_exp(input logic [7:0] l, input logic [7:0] d,
                                          input logic [7:0] x, input logic [7:0] s);
        return (d & l) | (~d & ~s & x);
    endfunction : rd_exp

    // one bus transfer, sampled mid-cycle
    task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] d,
                       output logic [7:0] v, output logic [1:0] rs);
        logic aok, wok, done;
        int t = 0;
        @(posedge clk_sys);
        if (w)
        begin
            s_axi_awaddr <= a;
            s_axi_wdata <= {24'h0, d};
            s_axi_awvalid <= 1'b1;
            s_axi_wvalid <= 1'b1;
            s_axi_bready <= 1'b1;
        end
        else
        begin
            s_axi_araddr <= a;
            s_axi_arvalid <= 1'b1;
            s_axi_rready <= 1'b1;
        end
        do
        begin
            @(negedge clk_sys);
            aok = w ? s_axi_awready : s_axi_arready;
            wok = s_axi_wready;
            done = w ? s_axi_bvalid : s_axi_rvalid;
            rs = w ? s_axi_bresp : s_axi_rresp;
            v = s_axi_rdata[7:0];
            @(posedge clk_sys);
            if (aok)
            begin
                s_axi_awvalid <= 1'b0;
                s_axi_arvalid <= 1'b0;
            end
            if (wok)
                s_axi_wvalid <= 1'b0;
            t++;
        end
        while (!done && t < 40);
        if (!done)
            num_errors++;
        s_axi_bready <= 1'b0;
        s_axi_rready <= 1'b0;
    endtask : bus

    // masked read check
    task automatic chk_rd(input logic [4:0] a, input logic [7:0] ex, input logic [7:0] mk,
                          input logic [1:0] er, input string n);
        logic [7:0] v;
        logic [1:0] rs;
        bus(1'b0, a, 8'h00, v, rs);
        `CHK(n, ex & mk, v & mk);
        `CHK("resp", er, rs);
    endtask : chk_rd

    // verdict
    task finish_test();
        $display("comparisons %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : finish_test

    // watchdog
    initial
    begin
        repeat (20000) @(posedge clk_sys);
        num_errors++;
        finish_test();
    end

    // main sequence
    initial
    begin
        repeat (2) @(posedge clk_sys);
        rst <= 1'b0;
        chk_rd(A_DB, 8'h00, 8'hFF, OK, "dir b reset");
        chk_rd(A_DC, 8'h00, 8'hFF, OK, "dir c reset");
        chk_rd(A_DD, 8'h00, 8'hFF, OK, "dir d reset");
        chk_rd(5'h00, 8'h00, 8'hFF, ERR, "hole 0");
        chk_rd(5'h10, 8'h00, 8'hFF, ERR, "hole 4");
        chk_rd(5'h05, 8'h00, 8'hFF, ERR, "misaligned");
        bus(1'b1, 5'h10, 8'hFF, rv, rr);
        `CHK("hole write", ERR, rr);
        for (int i = 0; i < 24; i++)
        begin
            r = rnd();
            q = {rnd(), rnd()};
            @(posedge clk_sys);
            analog_channel_select <= 5'(i);
            timer_prescale_select <= i[0] ? gpiobcd_pkg::TIMER_EXT_SEL : r[2:0];
            ext_b <= r[15:8];
            ext_c <= r[23:16] & 8'h1F;
            ext_d <= r[31:24] & 8'h7F;
            for (int k = 0; k < 6; k++)
                bus(1'b1, adr[k], q[k*8 +: 8], rv, rr);
            {dir_d, dir_c, dir_b, lat_d, lat_c, lat_b} = q[47:0] & 48'h7F9FFF7F1FFF;
            repeat (8) @(posedge clk_sys);
            sb = (i < 8) ? 8'h01 << i : 8'h00;
            sd = (i > 7 && i < 15) ? 8'h01 << (i - 8) : 8'h00;
            tx = timer_prescale_select == gpiobcd_pkg::TIMER_EXT_SEL;
            sd[6] = sd[6] | tx;
            ck = dir_c[7];
            m = (ck && !dir_c[2]) ? 8'hFB : 8'hFF;
            e = rd_exp(lat_c, dir_c & 8'h1F, ext_c, 8'h00);
            e[2] = e[2] & !ck;
            chk_rd(A_LB, rd_exp(lat_b, dir_b, ext_b, sb), 8'hFF, OK, "latch b");
            chk_rd(A_LC, e, m, OK, "latch c");
            chk_rd(A_LD, rd_exp(lat_d, dir_d, ext_d, sd), 8'hFF, OK, "latch d");
            chk_rd(A_DB, dir_b, 8'hFF, OK, "dir b");
            chk_rd(A_DC, dir_c, 8'hFF, OK, "dir c");
            chk_rd(A_DD, dir_d, 8'hFF, OK, "dir d");
            @(negedge clk_sys);
            `CHK("oe b", ~(dir_b & ~sb), pin_b_oe_n);
            `CHK("oe c", ~(dir_c[4:0] | {2'b00, ck, 2'b00}), pin_c_oe_n);
            `CHK("oe d", ~(dir_d[6:0] & ~sd[6:0]), pin_d_oe_n);
            `CHK("out b", lat_b, pin_b_out);
            `CHK("out c", lat_c[4:0] & {2'b11, !ck, 2'b11}, pin_c_out & {2'b11, !ck, 2'b11});
            `CHK("out d", lat_d[6:0], pin_d_out);
            `CHK("timer", tx & ext_d[6], timer_ext_clock_in);
            if (ck)
            begin
                b = pin_c_out[2];
                @(negedge clk_sys);
                `CHK("clock out", ~b, pin_c_out[2]);
            end
        end
        @(posedge clk_sys);
        rst <= 1'b1;
        repeat (2) @(posedge clk_sys);
        rst <= 1'b0;
        chk_rd(A_DC, 8'h00, 8'hFF, OK, "dir c again");
        bus(1'b1, A_DB, 8'hFF, rv, rr);
        chk_rd(A_LB, lat_b, 8'hFF, OK, "latch kept");
        finish_test();
    end
endmodule : gpiobcd_tb
